// ===== inc/osc_pkg.sv
// Constants shared by the OTP security block and its array store.
// Assumes one tile clock domain and a power-up reset applied before use.
package osc_pkg;

    // Array organisation
    localparam int OTP_SECTORS = 4;
    localparam int OTP_ROWS_PER_SECTOR = 512;
    localparam int OTP_ROW_BITS = 32;
    localparam int OTP_REDUNDANT_ROWS = 4;
    localparam int OTP_MAIN_ROWS = OTP_SECTORS * OTP_ROWS_PER_SECTOR;
    localparam int ROW_ADDR_W = 12;
    localparam int SECTOR_W = 2;

    // Row address layout: [8:0] row, [10:9] sector, [11] redundant area
    localparam int ADDR_ROW_LO = 0;
    localparam int ADDR_SECTOR_LO = 9;
    localparam int ADDR_REDUNDANT = 11;

    // Security configuration bit positions
    localparam int SEC_JTAG_OFF = 0;
    localparam int SEC_LINK_OFF = 1;
    localparam int SEC_SECURE_BOOT = 5;
    localparam int SEC_REDUNDANT = 7;
    localparam int SEC_SECTOR_LOCK_LO = 8;
    localparam int SEC_MASTER_LOCK = 12;
    localparam int SEC_JTAG_OTP_OFF = 13;
    localparam int USER_ID_LO = 22;
    localparam int USER_ID_W = 10;
    localparam logic [31:0] SEC_RESET = 32'h0000_0000;

    // Programming port resource identifiers and widths
    localparam logic [23:0] RES_PROG_ADDR = 24'h10_0200;
    localparam logic [23:0] RES_PROG_DATA = 24'h20_0100;
    localparam logic [23:0] RES_PROG_CTRL = 24'h10_0300;
    localparam int PROG_ADDR_W = 16;
    localparam int PROG_CTRL_W = 16;
    localparam int CTRL_WRITE_ROW = 0;
    localparam int CTRL_WRITE_SEC = 1;

    // Debug access instructions
    localparam int IR_W = 4;
    localparam logic [3:0] IR_JTAG_DEVICE_IDENTIFICATION = 4'h1;
    localparam logic [3:0] IR_USERCODE = 4'h2;
    localparam logic [3:0] IR_OTP_READ = 4'h3;
    localparam logic [3:0] IR_OTP_WRITE = 4'h4;
    localparam logic [3:0] IR_TILE_STATE = 4'h5;
    localparam logic [1:0] TAPS_PER_TILE = 2'h2;
    localparam int UC_REV_W = 16;

    typedef enum logic [1:0] {
        OSC_S_RESET = 2'b00,
        OSC_S_LOAD = 2'b01,
        OSC_S_COPY = 2'b10,
        OSC_S_RUN = 2'b11
    } osc_state_t;

endpackage

// ===== logic/osc_otp_array.sv
// One-time-programmable store: main rows, redundant rows and the security word.
// Assumes the caller checks locks; this store only ever sets bits.
`timescale 1ns/100ps
module osc_otp_array #(
    parameter int ROWS = osc_pkg::OTP_MAIN_ROWS,
    parameter int SPARE = osc_pkg::OTP_REDUNDANT_ROWS
) (
    input wire logic ref_clk,
    input wire logic [osc_pkg::ROW_ADDR_W-1:0] rd_row,
    output logic [31:0] rd_data,
    output logic [31:0] sec_data,
    input wire logic wr_en,
    input wire logic [osc_pkg::ROW_ADDR_W-1:0] wr_row,
    input wire logic [31:0] wr_data,
    input wire logic sec_wr_en,
    input wire logic [31:0] sec_wr_data
);
    // Blank cells read as zero, as an unprogrammed fuse array does; reset never touches them
    logic [31:0] main_mem [ROWS] = '{default: 32'h0000_0000};
    logic [31:0] spare_mem [SPARE] = '{default: 32'h0000_0000};
    logic [31:0] sec_mem = 32'h0000_0000;

    if (ROWS > (1 << osc_pkg::ADDR_REDUNDANT) || SPARE < 1) begin : g_bad_size
        $error("osc_otp_array: row counts do not fit the row address");
    end

    always_comb begin
        if (rd_row[osc_pkg::ADDR_REDUNDANT]) begin
            rd_data = spare_mem[rd_row[1:0] % SPARE];
        end else begin
            rd_data = main_mem[rd_row[osc_pkg::ADDR_REDUNDANT-1:0]];
        end
        sec_data = sec_mem;
    end

    // Writes OR into the cells so a programmed one can never return to zero
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            if (wr_row[osc_pkg::ADDR_REDUNDANT]) begin
                spare_mem[wr_row[1:0] % SPARE] <= spare_mem[wr_row[1:0] % SPARE] | wr_data;
            end else begin
                main_mem[wr_row[osc_pkg::ADDR_REDUNDANT-1:0]] <=
                    main_mem[wr_row[osc_pkg::ADDR_REDUNDANT-1:0]] | wr_data;
            end
        end
        if (sec_wr_en) begin
            sec_mem <= sec_mem | sec_wr_data;
        end
    end
endmodule

// ===== logic/osc_otp_security_config.sv
// Tile OTP security block: power-up load, boot copy, programming ports, debug and link gating, SRAM.
// Assumes all inputs synchronous to ref_clk and the far parties waiting for sec_ready.
`timescale 1ns/100ps

// Summary of operation
// - OTP: four sectors of 512 32-bit rows
// - Security word loaded before features act
// - Remaining OTP rows copied to SRAM first
// - Programming via address, data, control ports
// - Bit 0 shuts the debug interface
// - Bit 1 refuses link access to processor
// - Bit 5 boots from OTP address 0
// - Bit 7 enables redundant OTP rows
// - Bits 8-11 lock sectors 0-3
// - Bit 12 locks all programming
// - Bit 13 blocks debug OTP access
// - SRAM byte/half/word access in one cycle
// - Two TAPs per tile after reset
// - Chip TAP reaches tile, OTP
// - JTAG_DEVICE_IDENTIFICATION word with lowest bit set
// - USERCODE carries user ID from security bits
module osc_otp_security_config #(
    parameter int SRAM_WORDS = 32768,
    parameter int SRAM_AW = 15,
    parameter logic [3:0] ID_VERSION = 4'h1,       // Arbitrary value
    parameter logic [15:0] ID_PART = 16'h1234,     // Arbitrary value
    parameter logic [10:0] ID_MAKER = 11'h055,     // Arbitrary value
    parameter logic [15:0] SILICON_REV = 16'h0001  // Arbitrary value
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic prog_wr,
    input wire logic [23:0] prog_res_id,
    input wire logic [31:0] prog_wdata,
    output logic prog_ack,
    output logic prog_err,
    input wire logic trst_n,
    input wire logic jtag_req,
    input wire logic [osc_pkg::IR_W-1:0] jtag_ir,
    input wire logic [osc_pkg::ROW_ADDR_W-1:0] jtag_addr,
    input wire logic [31:0] jtag_wdata,
    output logic jtag_rsp_valid,
    output logic [31:0] jtag_rsp_data,
    output logic jtag_denied,
    output logic [1:0] jtag_tap_count,
    input wire logic link_req,
    output logic link_grant,
    output logic link_refuse,
    input wire logic cpu_req,
    input wire logic cpu_we,
    input wire logic [3:0] cpu_be,
    input wire logic [SRAM_AW-1:0] cpu_addr,
    input wire logic [31:0] cpu_wdata,
    output logic [31:0] cpu_rdata,
    output logic cpu_ack,
    output logic sec_ready,
    output logic [31:0] sec_word,
    output logic boot_start,
    output logic boot_from_otp
);
    if (SRAM_WORDS < osc_pkg::OTP_MAIN_ROWS || SRAM_WORDS > (1 << SRAM_AW)) begin : g_bad_sram
        $error("osc_otp_security_config: SRAM size cannot hold the boot copy");
    end

    typedef struct packed {
        osc_pkg::osc_state_t st;
        logic [osc_pkg::ROW_ADDR_W-1:0] row;
        logic [31:0] sec;
        logic [osc_pkg::PROG_ADDR_W-1:0] paddr;
        logic [31:0] pdata;
        logic prog_ack;
        logic prog_err;
        logic jvalid;
        logic [31:0] jdata;
        logic jdenied;
        logic lgrant;
        logic lrefuse;
        logic cack;
        logic boot_start;
        logic boot_otp;
    } osc_regs_t;

    osc_regs_t r;
    osc_regs_t next_r;

    logic [31:0] sram [SRAM_WORDS];
    logic [osc_pkg::ROW_ADDR_W-1:0] arr_rd_row;
    logic [31:0] arr_rd_data;
    logic [31:0] arr_sec_data;
    logic arr_wr_en;
    logic [osc_pkg::ROW_ADDR_W-1:0] arr_wr_row;
    logic [31:0] arr_wr_data;
    logic arr_sec_wr;
    logic [31:0] arr_sec_wr_data;
    logic sram_copy_we;

    // A row may be programmed only when neither master nor sector lock is set
    function automatic logic row_writable(input logic [31:0] sec, input logic [osc_pkg::ROW_ADDR_W-1:0] row);
        logic [osc_pkg::SECTOR_W-1:0] sector;
        sector = row[osc_pkg::ADDR_SECTOR_LO +: osc_pkg::SECTOR_W];
        row_writable = !sec[osc_pkg::SEC_MASTER_LOCK]
            && !sec[osc_pkg::SEC_SECTOR_LOCK_LO + int'(sector)]
            && (!row[osc_pkg::ADDR_REDUNDANT] || sec[osc_pkg::SEC_REDUNDANT]);
    endfunction

    function automatic logic row_readable(input logic [31:0] sec, input logic [osc_pkg::ROW_ADDR_W-1:0] row);
        row_readable = !row[osc_pkg::ADDR_REDUNDANT] || sec[osc_pkg::SEC_REDUNDANT];
    endfunction

    osc_otp_array #(
        .ROWS(osc_pkg::OTP_MAIN_ROWS),
        .SPARE(osc_pkg::OTP_REDUNDANT_ROWS)
    ) u_array (
        .ref_clk(ref_clk),
        .rd_row(arr_rd_row),
        .rd_data(arr_rd_data),
        .sec_data(arr_sec_data),
        .wr_en(arr_wr_en),
        .wr_row(arr_wr_row),
        .wr_data(arr_wr_data),
        .sec_wr_en(arr_sec_wr),
        .sec_wr_data(arr_sec_wr_data)
    );

    always_comb begin
        logic loaded;
        logic jtag_live;
        logic ctrl_go;
        logic [osc_pkg::PROG_CTRL_W-1:0] ctrl;
        logic [osc_pkg::ROW_ADDR_W-1:0] prow;
        logic [31:0] usercode;
        next_r = r;
        loaded = (r.st == osc_pkg::OSC_S_RUN);
        jtag_live = trst_n && jtag_req;
        ctrl = prog_wdata[osc_pkg::PROG_CTRL_W-1:0];
        prow = r.paddr[osc_pkg::ROW_ADDR_W-1:0];
        ctrl_go = 1'b0;
        usercode = '0;
        arr_rd_row = jtag_addr;
        arr_wr_en = 1'b0;
        arr_wr_row = prow;
        arr_wr_data = r.pdata;
        arr_sec_wr = 1'b0;
        arr_sec_wr_data = r.pdata;
        sram_copy_we = 1'b0;
        next_r.prog_ack = 1'b0;
        next_r.prog_err = 1'b0;
        next_r.jvalid = 1'b0;
        next_r.jdenied = 1'b0;
        next_r.lgrant = 1'b0;
        next_r.lrefuse = 1'b0;
        next_r.cack = 1'b0;
        next_r.boot_start = 1'b0;

        case (r.st)
            osc_pkg::OSC_S_RESET: begin
                next_r.st = osc_pkg::OSC_S_LOAD;
            end
            osc_pkg::OSC_S_LOAD: begin
                next_r.sec = arr_sec_data;
                next_r.row = '0;
                next_r.st = osc_pkg::OSC_S_COPY;
            end
            osc_pkg::OSC_S_COPY: begin
                // One row per cycle into the low SRAM words; the processor waits meanwhile
                arr_rd_row = r.row;
                sram_copy_we = 1'b1;
                if (int'(r.row) == osc_pkg::OTP_MAIN_ROWS - 1) begin
                    next_r.st = osc_pkg::OSC_S_RUN;
                    next_r.boot_start = 1'b1;
                    next_r.boot_otp = r.sec[osc_pkg::SEC_SECURE_BOOT];
                end else begin
                    next_r.row = r.row + 1'b1;
                end
            end
            osc_pkg::OSC_S_RUN: begin
                next_r.st = osc_pkg::OSC_S_RUN;
            end
            default: begin
                next_r.st = osc_pkg::OSC_S_RESET;
            end
        endcase

        // Programming ports: address and data are held, a control write fires
        if (prog_wr) begin
            if (prog_res_id == osc_pkg::RES_PROG_ADDR) begin
                next_r.paddr = prog_wdata[osc_pkg::PROG_ADDR_W-1:0];
                next_r.prog_ack = 1'b1;
            end else if (prog_res_id == osc_pkg::RES_PROG_DATA) begin
                next_r.pdata = prog_wdata;
                next_r.prog_ack = 1'b1;
            end else if (prog_res_id == osc_pkg::RES_PROG_CTRL) begin
                ctrl_go = 1'b1;
            end else begin
                next_r.prog_err = 1'b1;
            end
        end
        if (ctrl_go) begin
            if (!loaded) begin
                next_r.prog_err = 1'b1;
            end else if (ctrl[osc_pkg::CTRL_WRITE_SEC]) begin
                if (r.sec[osc_pkg::SEC_MASTER_LOCK]) begin
                    next_r.prog_err = 1'b1;
                end else begin
                    arr_sec_wr = 1'b1;
                    next_r.sec = r.sec | r.pdata;
                    next_r.prog_ack = 1'b1;
                end
            end else if (ctrl[osc_pkg::CTRL_WRITE_ROW]) begin
                if (row_writable(r.sec, prow)) begin
                    arr_wr_en = 1'b1;
                    next_r.prog_ack = 1'b1;
                end else begin
                    next_r.prog_err = 1'b1;
                end
            end else begin
                next_r.prog_ack = 1'b1;
            end
        end

        // Debug access through the chip TAP; held quiet while its reset is low
        usercode[osc_pkg::USER_ID_LO +: osc_pkg::USER_ID_W] =
            r.sec[osc_pkg::USER_ID_LO +: osc_pkg::USER_ID_W];
        usercode[osc_pkg::UC_REV_W-1:0] = SILICON_REV;
        if (jtag_live) begin
            next_r.jvalid = 1'b1;
            next_r.jdata = '0;
            if (!loaded || r.sec[osc_pkg::SEC_JTAG_OFF]) begin
                next_r.jdenied = 1'b1;
            end else begin
                case (jtag_ir)
                    osc_pkg::IR_JTAG_DEVICE_IDENTIFICATION: begin
                        next_r.jdata = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
                    end
                    osc_pkg::IR_USERCODE: begin
                        next_r.jdata = usercode;
                    end
                    osc_pkg::IR_TILE_STATE: begin
                        next_r.jdata = r.sec;
                    end
                    osc_pkg::IR_OTP_READ: begin
                        if (r.sec[osc_pkg::SEC_JTAG_OTP_OFF] || !row_readable(r.sec, jtag_addr)) begin
                            next_r.jdenied = 1'b1;
                        end else begin
                            next_r.jdata = arr_rd_data;
                        end
                    end
                    osc_pkg::IR_OTP_WRITE: begin
                        // The programming ports own the write path when both fire together
                        if (r.sec[osc_pkg::SEC_JTAG_OTP_OFF] || ctrl_go
                            || !row_writable(r.sec, jtag_addr)) begin
                            next_r.jdenied = 1'b1;
                        end else begin
                            arr_wr_en = 1'b1;
                            arr_wr_row = jtag_addr;
                            arr_wr_data = jtag_wdata;
                        end
                    end
                    default: begin
                        next_r.jdata = '0;
                    end
                endcase
            end
        end

        // Link access to processor state
        if (link_req) begin
            if (loaded && !r.sec[osc_pkg::SEC_LINK_OFF]) begin
                next_r.lgrant = 1'b1;
            end else begin
                next_r.lrefuse = 1'b1;
            end
        end

        next_r.cack = cpu_req && loaded;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '{st: osc_pkg::OSC_S_RESET, sec: osc_pkg::SEC_RESET, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // SRAM: copy port during boot, processor port after; each access ends in one cycle
    always_ff @(posedge ref_clk) begin
        if (sram_copy_we) begin
            sram[r.row[osc_pkg::ADDR_REDUNDANT-1:0]] <= arr_rd_data;
        end else if (cpu_req && r.st == osc_pkg::OSC_S_RUN) begin
            if (cpu_we) begin
                for (int b = 0; b < 4; b++) begin
                    if (cpu_be[b]) begin
                        sram[cpu_addr][8*b +: 8] <= cpu_wdata[8*b +: 8];
                    end
                end
            end
            cpu_rdata <= sram[cpu_addr];
        end
    end

    assign prog_ack = r.prog_ack;
    assign prog_err = r.prog_err;
    assign jtag_rsp_valid = r.jvalid;
    assign jtag_rsp_data = r.jdata;
    assign jtag_denied = r.jdenied;
    assign jtag_tap_count = osc_pkg::TAPS_PER_TILE;
    assign link_grant = r.lgrant;
    assign link_refuse = r.lrefuse;
    assign cpu_ack = r.cack;
    assign sec_ready = (r.st == osc_pkg::OSC_S_RUN);
    assign sec_word = r.sec;
    assign boot_start = r.boot_start;
    assign boot_from_otp = r.boot_otp;

    AST_SEC_MONOTONIC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        r.st == osc_pkg::OSC_S_RUN |=> (r.sec & $past(r.sec)) == $past(r.sec))
        else $error("security bit returned to zero");

    AST_BOOT_AFTER_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(r.st == osc_pkg::OSC_S_COPY) |-> r.sec == $past(arr_sec_data))
        else $error("security word not loaded before copy");

    AST_JTAG_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        jtag_req && trst_n && r.sec[osc_pkg::SEC_JTAG_OFF] |=> jtag_rsp_valid && jtag_denied && jtag_rsp_data == '0)
        else $error("debug access served while disabled");

    AST_LINK_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        link_req && r.sec[osc_pkg::SEC_LINK_OFF] |=> link_refuse && !link_grant)
        else $error("link access granted while disabled");

    AST_BOOT_SRC: assert property (@(posedge ref_clk) disable iff (!rst_n)
        boot_start |-> boot_from_otp == r.sec[osc_pkg::SEC_SECURE_BOOT] && $past(r.st) == osc_pkg::OSC_S_COPY)
        else $error("boot source does not follow secure boot bit");

    AST_SECTOR_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        prog_wr && prog_res_id == osc_pkg::RES_PROG_CTRL && prog_wdata[osc_pkg::CTRL_WRITE_ROW]
        && !prog_wdata[osc_pkg::CTRL_WRITE_SEC]
        && r.sec[osc_pkg::SEC_SECTOR_LOCK_LO + int'(r.paddr[osc_pkg::ADDR_SECTOR_LO +: osc_pkg::SECTOR_W])]
        |=> prog_err && !prog_ack)
        else $error("locked sector was programmed");

    AST_MASTER_LOCK: assert property (@(posedge ref_clk) disable iff (!rst_n)
        prog_wr && prog_res_id == osc_pkg::RES_PROG_CTRL && r.sec[osc_pkg::SEC_MASTER_LOCK]
        && (prog_wdata[osc_pkg::CTRL_WRITE_ROW] || prog_wdata[osc_pkg::CTRL_WRITE_SEC])
        |-> !arr_wr_en ##1 prog_err)
        else $error("programming accepted under master lock");

    AST_JTAG_OTP_OFF: assert property (@(posedge ref_clk) disable iff (!rst_n)
        jtag_req && trst_n && r.sec[osc_pkg::SEC_JTAG_OTP_OFF]
        && (jtag_ir == osc_pkg::IR_OTP_READ || jtag_ir == osc_pkg::IR_OTP_WRITE) |=> jtag_denied)
        else $error("debug reached OTP while blocked");

    AST_SRAM_ONE_CYCLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        cpu_req && sec_ready |=> cpu_ack)
        else $error("SRAM access took more than one cycle");

    AST_JTAG_DEVICE_IDENTIFICATION_LSB: assert property (@(posedge ref_clk) disable iff (!rst_n)
        jtag_req && trst_n && jtag_ir == osc_pkg::IR_JTAG_DEVICE_IDENTIFICATION && sec_ready && !r.sec[osc_pkg::SEC_JTAG_OFF]
        |=> jtag_rsp_valid && jtag_rsp_data[0] && !jtag_denied)
        else $error("identification word malformed");

endmodule

// ===== verif/osc_host_model.sv
// Debug host model: owns the debug reset line and issues debug requests.
// Assumes it shares the tile clock and that the bench calls req between checks.
`timescale 1ns/100ps
module osc_host_model (
    input wire logic ref_clk,
    output logic trst_n,
    output logic jtag_req,
    output logic [osc_pkg::IR_W-1:0] jtag_ir,
    output logic [osc_pkg::ROW_ADDR_W-1:0] jtag_addr,
    output logic [31:0] jtag_wdata
);
    initial begin
        trst_n = 1'b0;
        jtag_req = 1'b0;
        jtag_ir = 4'h0;
        jtag_addr = 12'h000;
        jtag_wdata = 32'h0000_0000;
        #104 trst_n = 1'b1; // Held low past 100 ns after power-up
    end

    task automatic req(input logic [3:0] ir, input logic [11:0] a, input logic [31:0] wd);
        @(negedge ref_clk);
        jtag_req = 1'b1;
        jtag_ir = ir;
        jtag_addr = a;
        jtag_wdata = wd;
        @(negedge ref_clk);
        jtag_req = 1'b0;
        // Released address and write-data lines carry the inverse so a stale value is never trusted
        jtag_addr = ~a;
        jtag_wdata = ~wd;
    endtask
endmodule

// ===== verif/osc_otp_security_config_test.sv
// Self-checking bench for the tile OTP security block.
// Assumes a 4096-word SRAM build and a blank OTP at simulation start.
`timescale 1ns/100ps
module osc_otp_security_config_test;
    localparam logic [3:0] VER = 4'h3; // Arbitrary value
    localparam logic [15:0] PART = 16'h00A5; // Arbitrary value
    localparam logic [10:0] MAKER = 11'h07E; // Arbitrary value
    localparam logic [15:0] REV = 16'h0042; // Arbitrary value
    localparam logic [23:0] PA = osc_pkg::RES_PROG_ADDR;
    localparam logic [23:0] PD = osc_pkg::RES_PROG_DATA;
    localparam logic [23:0] PC = osc_pkg::RES_PROG_CTRL;
    typedef struct packed {logic [3:0] ir; logic [31:0] d;} osc_row_t;
    logic ref_clk, rst_n, prog_wr, prog_ack, prog_err, trst_n, jtag_req, jtag_rsp_valid, jtag_denied;
    logic link_req, link_grant, link_refuse, cpu_req, cpu_we, cpu_ack, sec_ready, boot_start, boot_from_otp;
    logic [23:0] prog_res_id;
    logic [31:0] prog_wdata, jtag_wdata, jtag_rsp_data, cpu_wdata, cpu_rdata, sec_word, sec_exp;
    logic [3:0] jtag_ir, cpu_be;
    logic [11:0] jtag_addr, cpu_addr;
    logic [1:0] jtag_tap_count;
    int n_fail = 0;
    int total_checks = 0;
    osc_row_t rows [4];

    osc_otp_security_config #(.SRAM_WORDS(4096), .SRAM_AW(12), .ID_VERSION(VER), .ID_PART(PART),
        .ID_MAKER(MAKER), .SILICON_REV(REV)) osc_otp_security_config_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .prog_wr(prog_wr), .prog_res_id(prog_res_id), .prog_wdata(prog_wdata), .prog_ack(prog_ack),
        .prog_err(prog_err), .trst_n(trst_n), .jtag_req(jtag_req), .jtag_ir(jtag_ir), .jtag_addr(jtag_addr),
        .jtag_wdata(jtag_wdata), .jtag_rsp_valid(jtag_rsp_valid), .jtag_rsp_data(jtag_rsp_data),
        .jtag_denied(jtag_denied), .jtag_tap_count(jtag_tap_count), .link_req(link_req),
        .link_grant(link_grant), .link_refuse(link_refuse), .cpu_req(cpu_req), .cpu_we(cpu_we),
        .cpu_be(cpu_be), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
        .sec_ready(sec_ready), .sec_word(sec_word), .boot_start(boot_start), .boot_from_otp(boot_from_otp));
    osc_host_model osc_host_model_i (.ref_clk(ref_clk), .trst_n(trst_n), .jtag_req(jtag_req),
        .jtag_ir(jtag_ir), .jtag_addr(jtag_addr), .jtag_wdata(jtag_wdata));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic prog(input logic [23:0] id, input logic [31:0] d, input logic e);
        @(negedge ref_clk);
        prog_wr = 1'b1;
        prog_res_id = id;
        prog_wdata = d;
        @(negedge ref_clk);
        prog_wr = 1'b0;
        prog_wdata = ~d;
        chk({32'h0, prog_ack, prog_err}, {32'h0, ~e, e});
    endtask

    task automatic row(input logic [11:0] a, input logic [31:0] d, input logic e);
        prog(PA, {20'h0, a}, 1'b0);
        prog(PD, d, 1'b0);
        prog(PC, 32'h0000_0001, e);
    endtask

    task automatic sec(input logic [31:0] d, input logic e);
        prog(PD, d, 1'b0);
        prog(PC, 32'h0000_0002, e);
        if (!e) begin
            sec_exp = sec_exp | d;
        end
        chk({2'b00, sec_word}, {2'b00, sec_exp});
    endtask

    task automatic jt(input logic [3:0] ir, input logic [11:0] a, input logic [31:0] wd, input logic den,
        input logic [31:0] exp);
        osc_host_model_i.req(ir, a, wd);
        chk({jtag_rsp_valid, jtag_denied, jtag_rsp_data}, {1'b1, den, den ? 32'h0 : exp});
    endtask

    task automatic link(input logic r);
        @(negedge ref_clk);
        link_req = 1'b1;
        @(negedge ref_clk);
        link_req = 1'b0;
        chk({32'h0, link_grant, link_refuse}, {32'h0, ~r, r});
    endtask

    task automatic cpu(input logic we, input logic [3:0] be, input logic [11:0] a, input logic [31:0] wd,
        input logic [31:0] exp);
        @(negedge ref_clk);
        cpu_req = 1'b1;
        cpu_we = we;
        cpu_be = be;
        cpu_addr = a;
        cpu_wdata = wd;
        @(negedge ref_clk);
        cpu_req = 1'b0;
        cpu_wdata = ~wd;
        chk({cpu_ack, 1'b1, cpu_rdata}, {2'b11, exp});
    endtask

    task automatic boot();
        int i;
        rst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({sec_ready, boot_from_otp, sec_word}, 34'h0);
        rst_n = 1'b1;
        for (i = 0; i < 3000 && sec_ready !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        if (sec_ready !== 1'b1) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, sec_ready, 1'b1);
            stop_test();
        end
    endtask

    initial begin
        {rst_n, prog_wr, link_req, cpu_req, cpu_we} = 5'h00;
        {prog_res_id, prog_wdata, cpu_be, cpu_addr, cpu_wdata} = '0;
        sec_exp = 32'h0000_0000;
        rows = '{'{osc_pkg::IR_JTAG_DEVICE_IDENTIFICATION, {VER, PART, MAKER, 1'b1}}, '{osc_pkg::IR_USERCODE, {16'h0, REV}},
            '{osc_pkg::IR_TILE_STATE, 32'h0}, '{4'hF, 32'h0}};
        rst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        chk({32'h0, jtag_tap_count}, 34'h2);
        rst_n = 1'b1;
        repeat (12) @(negedge ref_clk);
        jt(osc_pkg::IR_JTAG_DEVICE_IDENTIFICATION, 12'h000, 32'h0, 1'b1, 32'h0);
        link(1'b1);
        prog(PC, 32'h0000_0001, 1'b1);
        repeat (2040) @(negedge ref_clk);
        boot();
        chk({33'h0, boot_from_otp}, 34'h0);
        foreach (rows[k]) jt(rows[k].ir, 12'h000, 32'h0, 1'b0, rows[k].d);
        link(1'b0);
        prog(24'h10_0400, 32'h0, 1'b1);
        row(12'h205, 32'hA5A5_0F0F, 1'b0);
        jt(osc_pkg::IR_OTP_READ, 12'h205, 32'h0, 1'b0, 32'hA5A5_0F0F);
        jt(osc_pkg::IR_OTP_WRITE, 12'h7FF, 32'h0000_00FF, 1'b0, 32'h0);
        jt(osc_pkg::IR_OTP_READ, 12'h7FF, 32'h0, 1'b0, 32'h0000_00FF);
        cpu(1'b1, 4'hF, 12'h010, 32'h1122_3344, 32'h0);
        cpu(1'b1, 4'h2, 12'h010, 32'h0000_AA00, 32'h1122_3344);
        cpu(1'b0, 4'h0, 12'h010, 32'h0, 32'h1122_AA44);
        sec(32'h0040_0202, 1'b0);
        link(1'b1);
        jt(osc_pkg::IR_USERCODE, 12'h000, 32'h0, 1'b0, {10'h001, 6'h0, REV});
        row(12'h206, 32'h1, 1'b1);
        row(12'h003, 32'h1, 1'b0);
        row(12'h800, 32'h1, 1'b1);
        sec(32'h0000_0080, 1'b0);
        row(12'h801, 32'h1, 1'b0);
        sec(32'h0000_2000, 1'b0);
        jt(osc_pkg::IR_OTP_READ, 12'h205, 32'h0, 1'b1, 32'h0);
        jt(osc_pkg::IR_JTAG_DEVICE_IDENTIFICATION, 12'h000, 32'h0, 1'b0, {VER, PART, MAKER, 1'b1});
        sec(32'h0000_0001, 1'b0);
        jt(osc_pkg::IR_JTAG_DEVICE_IDENTIFICATION, 12'h000, 32'h0, 1'b1, 32'h0);
        sec(32'h0000_1020, 1'b0);
        row(12'h400, 32'h1, 1'b1);
        sec(32'h0000_0004, 1'b1);
        boot();
        chk({32'h0, boot_start, boot_from_otp}, 34'h3);
        chk({2'b00, sec_word}, {2'b00, sec_exp});
        cpu(1'b0, 4'h0, 12'h205, 32'h0, 32'hA5A5_0F0F);
        stop_test();
    end
endmodule
